// ===== core/serial_frame_ctrl.sv
// Asynchronous serial transmitter and receiver with register port.
// Assumes a single-cycle read/write strobe master on MCLK; RXD is asynchronous.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "serial_map.svh"
module serial_frame_ctrl import serial_pkg::*; (
  input wire logic MCLK, // Bus clock, 50 MHz
  input wire logic RSTN, // Asynchronous reset, active low
  input wire logic [2:0] ADDR, // Register index
  input wire logic [7:0] WDATA, // Write data
  input wire logic WR, // Write strobe
  input wire logic RD, // Read strobe
  output logic [7:0] RDATA, // Read data, cycle after RD
  input wire logic RXD, // Receive line
  output logic TXD, // Transmit line
  output logic TX_IRQ, // Transmitter interrupt request
  output logic ERR_IRQ // Receiver error interrupt request
);
  logic rst_meta_reg, rst_n; // Reset release synchroniser
  logic rxd_meta_reg, rxd_sync_reg; // Receive line synchroniser
  logic [7:0] ctrl_one_reg, ctrl_two_reg; // Control registers
  logic [3:0] err_ie_reg; // Error enables of control three
  logic tx8_reg; // Ninth transmit bit
  logic rx8_reg; // Ninth received bit, no reset
  logic [7:0] baud_reg; // Bit period divisor
  logic [7:0] tx_buf_reg; // Transmit data register
  logic [7:0] rx_data_reg; // Receive data register
  logic tx_empty_flag_reg, transmission_done_flag_reg; // Transmit flags
  logic rx_full_flag_reg, overrun_reg; // Receive flags
  logic noise_error_flag_reg, framing_error_flag_reg, parity_error_flag_reg;
  logic break_seen_flag_reg; // Break received
  logic tx_on_prev_reg; // Enable edge detector
  logic idle_pending_reg; // Queued idle character
  tx_state_e tx_state_reg; // Transmit sequencer
  logic [10:0] tx_shift_reg; // Outgoing frame, LSB first
  logic [3:0] tx_left_reg; // Bits still to send
  logic [11:0] tx_cnt_reg; // Cycle within bit
  logic [11:0] bit_cycles; // Clocks per bit
  logic width9, flip, par_en, par_odd, tx_on, rx_on, send_brk; // Control fields
  logic wr_data, rd_data; // Data register access
  logic tx_start, tx_load_data; // Shifter load events
  logic tx_bit_end; // Last cycle of a bit
  logic [3:0] frame_len; // Bits per frame
  logic [10:0] data_frame; // Framed data character
  logic tx_par; // Transmit parity
  logic done_set; // Transmitter fully drained
  logic rx_done, rx_ferr, rx_perr, rx_noise, rx_brk, rx_act; // Receiver results
  logic [8:0] rx_word; // Receiver character
  logic [7:0] s1_view, s2_view; // Status read views
  logic [7:0] rd_mux; // Read data source

  assign width9 = ctrl_one_reg[`C1_WIDTH9];
  assign flip = ctrl_one_reg[`C1_FLIP];
  assign par_en = ctrl_one_reg[`C1_PAR_EN];
  assign par_odd = ctrl_one_reg[`C1_PAR_ODD];
  assign tx_on = ctrl_two_reg[`C2_TX_ON];
  assign rx_on = ctrl_two_reg[`C2_RX_ON];
  assign send_brk = ctrl_two_reg[`C2_SEND_BRK];
  assign bit_cycles = ({4'h0, baud_reg} + 12'h001) * `BIT_MULT;
  assign wr_data = WR && (ADDR == `ADDR_DATA);
  assign rd_data = RD && (ADDR == `ADDR_DATA);

  // Reset is released through two flops so all flops leave reset together
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // Receive line synchroniser; idles high
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
    end else begin
      rxd_meta_reg <= RXD;
      rxd_sync_reg <= rxd_meta_reg;
    end
  end

  // Software-written control
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_one_reg <= `CTRL_RST;
      ctrl_two_reg <= `CTRL_RST;
      err_ie_reg <= 4'h0; // [R14] [R15] [R16] [R17]
      tx8_reg <= 1'b0; // [R13]
      baud_reg <= `BAUD_RST;
      tx_buf_reg <= 8'h00;
    end else if (WR) begin
      unique case (ADDR)
        `ADDR_CTRL_ONE: ctrl_one_reg <= WDATA;
        `ADDR_CTRL_TWO: ctrl_two_reg <= WDATA;
        `ADDR_CTRL_THREE: begin
          tx8_reg <= WDATA[`C3_TX8];
          err_ie_reg <= WDATA[3:0];
        end
        `ADDR_BAUD: baud_reg <= WDATA;
        `ADDR_DATA: tx_buf_reg <= WDATA;
        default: ;
      endcase
    end
  end

  // Transmit framing: parity replaces the top data bit position
  always_comb begin
    tx_par = (width9 ? ^tx_buf_reg : ^tx_buf_reg[6:0]) ^ par_odd;
    frame_len = width9 ? 4'hB : 4'hA; // [R3]
    if (width9) begin
      data_frame = {1'b1, (par_en ? tx_par : tx8_reg), tx_buf_reg, 1'b0}; // [R13]
    end else begin
      data_frame = {2'b11, (par_en ? tx_par : tx_buf_reg[7]), tx_buf_reg[6:0], 1'b0};
    end
  end

  // Nothing starts while the enable is low; a running frame is left alone
  assign tx_start = (tx_state_reg == TX_IDLE) && tx_on &&
                    (idle_pending_reg || send_brk || !tx_empty_flag_reg); // [R5]
  assign tx_load_data = tx_start && !idle_pending_reg && !send_brk;
  assign tx_bit_end = (tx_cnt_reg == bit_cycles - 12'h001);
  assign done_set = (tx_state_reg == TX_IDLE) && tx_empty_flag_reg &&
                    !idle_pending_reg && !send_brk; // [R9]

  // Enable edges queue an idle: the preamble, and re-enable mid-frame
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_on_prev_reg <= 1'b0;
      idle_pending_reg <= 1'b0;
    end else begin
      tx_on_prev_reg <= tx_on;
      if (tx_on && !tx_on_prev_reg) begin
        idle_pending_reg <= 1'b1; // [R4] [R6]
      end else if (tx_start) begin
        idle_pending_reg <= 1'b0;
      end
    end
  end

  // Transmit shifter
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 11'h7FF;
      tx_left_reg <= 4'h0;
      tx_cnt_reg <= 12'h000;
    end else begin
      unique case (tx_state_reg)
        TX_IDLE: begin
          tx_cnt_reg <= 12'h000;
          if (tx_start) begin
            tx_state_reg <= TX_SHIFT;
            tx_left_reg <= frame_len; // [R3]
            if (idle_pending_reg) tx_shift_reg <= 11'h7FF; // [R2]
            else if (send_brk) tx_shift_reg <= 11'h000;
            else tx_shift_reg <= data_frame;
          end
        end
        TX_SHIFT: begin
          tx_cnt_reg <= tx_bit_end ? 12'h000 : tx_cnt_reg + 12'h001;
          if (tx_bit_end) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
            tx_left_reg <= tx_left_reg - 4'h1;
            if (tx_left_reg == 4'h1) tx_state_reg <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // Line output; idle between frames is a one before inversion
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      TXD <= 1'b1;
    end else begin
      TXD <= ((tx_state_reg == TX_SHIFT) ? tx_shift_reg[0] : 1'b1) ^ flip; // [R7]
    end
  end

  // Transmit flags; empty set wins over a simultaneous data write, which wins over the done set
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_empty_flag_reg <= 1'b1;
      transmission_done_flag_reg <= 1'b1;
    end else begin
      if (tx_load_data) tx_empty_flag_reg <= 1'b1; // [R8]
      else if (wr_data) tx_empty_flag_reg <= 1'b0; // [R19]
      if (done_set && !wr_data) transmission_done_flag_reg <= 1'b1; // [R9]
      else if (wr_data || tx_start) transmission_done_flag_reg <= 1'b0;
    end
  end

  serial_rx u_rx (
    .clk(MCLK),
    .rst_n(rst_n),
    .rxd(rxd_sync_reg),
    .enable(rx_on),
    .nine(width9),
    .par_en(par_en),
    .par_odd(par_odd),
    .bit_cycles(bit_cycles),
    .done(rx_done),
    .data(rx_word),
    .frame_err(rx_ferr),
    .par_err(rx_perr),
    .noise(rx_noise),
    .brk(rx_brk),
    .active(rx_act)
  );

  // Receive data; an unread character is kept and overrun flagged instead
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_reg <= 8'h00;
    end else if (rx_done && !rx_full_flag_reg) begin
      rx_data_reg <= rx_brk ? 8'h00 : rx_word[7:0]; // [R1]
    end
  end

  // Ninth received bit has no reset
  always_ff @(posedge MCLK) begin
    if (rx_done && !rx_full_flag_reg) begin
      if (rx_brk) rx8_reg <= 1'b0; // [R1]
      else rx8_reg <= width9 ? rx_word[8] : rx_word[7]; // [R11] [R12]
    end
  end

  // Receive flags: hardware set wins; errors clear by writing ones
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_full_flag_reg <= 1'b0;
      overrun_reg <= 1'b0;
      noise_error_flag_reg <= 1'b0;
      framing_error_flag_reg <= 1'b0;
      parity_error_flag_reg <= 1'b0;
      break_seen_flag_reg <= 1'b0;
    end else begin
      if (rx_done) rx_full_flag_reg <= 1'b1; // [R1]
      else if (rd_data) rx_full_flag_reg <= 1'b0; // [R19]
      if (rx_done && rx_full_flag_reg) overrun_reg <= 1'b1;
      else if (WR && ADDR == `ADDR_STAT_ONE && WDATA[`S1_OR]) overrun_reg <= 1'b0;
      if (rx_done && rx_noise) noise_error_flag_reg <= 1'b1;
      else if (WR && ADDR == `ADDR_STAT_ONE && WDATA[`S1_NE]) noise_error_flag_reg <= 1'b0;
      if (rx_done && rx_ferr) framing_error_flag_reg <= 1'b1; // [R1]
      else if (WR && ADDR == `ADDR_STAT_ONE && WDATA[`S1_FE]) framing_error_flag_reg <= 1'b0;
      if (rx_done && rx_perr) parity_error_flag_reg <= 1'b1;
      else if (WR && ADDR == `ADDR_STAT_ONE && WDATA[`S1_PE]) parity_error_flag_reg <= 1'b0;
      if (rx_done && rx_brk) break_seen_flag_reg <= 1'b1; // [R1]
      else if (WR && ADDR == `ADDR_STAT_TWO && WDATA[`S2_BRK]) break_seen_flag_reg <= 1'b0;
    end
  end

  // Interrupt requests, registered so outputs come from flops
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      TX_IRQ <= 1'b0;
      ERR_IRQ <= 1'b0;
    end else begin
      TX_IRQ <= (tx_empty_flag_reg && ctrl_two_reg[`C2_TXE_IE]) || // [R8]
                (transmission_done_flag_reg && ctrl_two_reg[`C2_DONE_IE]); // [R9]
      ERR_IRQ <= (overrun_reg && err_ie_reg[`C3_OR_IE]) || // [R14] [R18]
                 (noise_error_flag_reg && err_ie_reg[`C3_NE_IE]) || // [R15]
                 (framing_error_flag_reg && err_ie_reg[`C3_FE_IE]) || // [R16]
                 (parity_error_flag_reg && err_ie_reg[`C3_PE_IE]); // [R17]
    end
  end

  assign s1_view = {tx_empty_flag_reg, transmission_done_flag_reg, rx_full_flag_reg, 1'b0,
                    overrun_reg, noise_error_flag_reg, framing_error_flag_reg,
                    parity_error_flag_reg};
  assign s2_view = {6'h00, break_seen_flag_reg, rx_act};

  // Read decode; unmapped addresses read zero
  always_comb begin
    unique case (ADDR)
      `ADDR_CTRL_ONE: rd_mux = ctrl_one_reg;
      `ADDR_CTRL_TWO: rd_mux = ctrl_two_reg;
      `ADDR_CTRL_THREE: rd_mux = {rx8_reg, tx8_reg, 2'b00, err_ie_reg};
      `ADDR_STAT_ONE: rd_mux = s1_view;
      `ADDR_STAT_TWO: rd_mux = s2_view;
      `ADDR_DATA: rd_mux = rx_data_reg;
      `ADDR_BAUD: rd_mux = baud_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) RDATA <= 8'h00;
    else RDATA <= RD ? rd_mux : 8'h00;
  end

  // Break frame loads zero data and sets the break flag
  property p_brk;
    @(posedge MCLK) disable iff (!rst_n)
    (rx_done && rx_brk && !rx_full_flag_reg) |=> (rx_data_reg == 8'h00) && !rx8_reg &&
      break_seen_flag_reg && framing_error_flag_reg && rx_full_flag_reg;
  endproperty
  a_brk: assert property (p_brk) // [R1]
    else $error("break did not update receive state");

  // Idle line is one when not inverted
  property p_idle_line;
    @(posedge MCLK) disable iff (!rst_n)
    (tx_state_reg == TX_IDLE && !flip) |=> TXD;
  endproperty
  a_idle_line: assert property (p_idle_line) // [R2]
    else $error("idle line not high");

  // Frame length follows width select
  property p_len;
    @(posedge MCLK) disable iff (!rst_n)
    tx_start |=> (tx_left_reg == (width9 ? 4'hB : 4'hA));
  endproperty
  a_len: assert property (p_len) // [R3]
    else $error("frame length wrong");

  // Enabling queues an idle on the next cycle
  property p_preamble;
    @(posedge MCLK) disable iff (!rst_n)
    (tx_on && !tx_on_prev_reg) |=> idle_pending_reg;
  endproperty
  a_preamble: assert property (p_preamble) // [R4] [R6]
    else $error("no idle queued on enable");

  // With enable low the shifter never starts
  property p_stop;
    @(posedge MCLK) disable iff (!rst_n)
    (tx_state_reg == TX_IDLE && !tx_on) |=> (tx_state_reg == TX_IDLE);
  endproperty
  a_stop: assert property (p_stop) // [R5]
    else $error("transmit started while disabled");

  // Inversion applies to the line in every shift cycle
  property p_flip;
    @(posedge MCLK) disable iff (!rst_n)
    (tx_state_reg == TX_SHIFT && $stable(flip)) |=>
      (TXD == ($past(tx_shift_reg[0]) ^ $past(flip)));
  endproperty
  a_flip: assert property (p_flip) // [R7]
    else $error("line polarity wrong");

  // Data load sets the empty flag and request follows
  property p_txe;
    @(posedge MCLK) disable iff (!rst_n)
    (tx_load_data && ctrl_two_reg[`C2_TXE_IE] && $stable(ctrl_two_reg)) |=> ##1 TX_IRQ;
  endproperty
  a_txe: assert property (p_txe) // [R8]
    else $error("empty interrupt missing");

  // Done flag only while drained
  property p_done;
    @(posedge MCLK) disable iff (!rst_n)
    $rose(transmission_done_flag_reg) |-> tx_state_reg == TX_IDLE && tx_empty_flag_reg;
  endproperty
  a_done: assert property (p_done) // [R9]
    else $error("done flag set while busy");

  // Error request follows the enabled framing flag
  property p_err;
    @(posedge MCLK) disable iff (!rst_n)
    (framing_error_flag_reg && err_ie_reg[`C3_FE_IE]) |=> ERR_IRQ;
  endproperty
  a_err: assert property (p_err) // [R16] [R18]
    else $error("error interrupt missing");

  // Overrun flag persists without a clearing write
  property p_hold;
    @(posedge MCLK) disable iff (!rst_n)
    (overrun_reg && !WR) |=> overrun_reg;
  endproperty
  a_hold: assert property (p_hold) // [R19]
    else $error("overrun flag dropped");
endmodule

// ===== core/serial_map.svh
// Register offsets, field positions, reset values and timing counts for the serial block.
// Assumes a byte-wide register port with a 3-bit address and one bus clock.
// Contract
// [R1] Break sets framing, full, break; clears data, ninth
// [R2] Idle character is all ones, no framing
// [R3] Idle length follows 8/9-bit width select
// [R4] Preamble idle precedes first data character; a character already buffered at enable goes out first, then the idle
// [R5] Clearing enable finishes current character, then idle
// [R6] Enable off-then-on queues one idle character
// [R7] Polarity flip inverts every transmitted bit
// [R8] Empty flag on buffer-to-shifter move; gated interrupt
// [R9] Done flag when all empty; gated interrupt
// [R10] Receiver takes 8 or 9 bit characters
// [R11] Ninth received bit stored with data
// [R12] 8-bit mode: ninth copies bit 7; reset-free
// [R13] Ninth transmit bit loaded with data; reset clears
// [R14] Overrun enable gates error interrupt
// [R15] Noise enable gates error interrupt
// [R16] Framing enable gates error interrupt
// [R17] Parity enable gates error interrupt
// [R18] Four gated errors form one error interrupt
// [R19] Flags held until software clears them
`ifndef SERIAL_MAP_SVH
`define SERIAL_MAP_SVH
// Register offsets
`define ADDR_CTRL_ONE 3'h0
`define ADDR_CTRL_TWO 3'h1
`define ADDR_CTRL_THREE 3'h2
`define ADDR_STAT_ONE 3'h3
`define ADDR_STAT_TWO 3'h4
`define ADDR_DATA 3'h5
`define ADDR_BAUD 3'h6
// Control one fields
`define C1_WIDTH9 4
`define C1_FLIP 5
`define C1_PAR_EN 1
`define C1_PAR_ODD 0
// Control two fields
`define C2_TXE_IE 7
`define C2_DONE_IE 6
`define C2_TX_ON 3
`define C2_RX_ON 2
`define C2_SEND_BRK 0
// Control three fields
`define C3_RX8 7
`define C3_TX8 6
`define C3_OR_IE 3
`define C3_NE_IE 2
`define C3_FE_IE 1
`define C3_PE_IE 0
// Status one fields
`define S1_TXE 7
`define S1_DONE 6
`define S1_FULL 5
`define S1_OR 3
`define S1_NE 2
`define S1_FE 1
`define S1_PE 0
// Status two fields
`define S2_BRK 1
`define S2_ACT 0
// Reset values
`define CTRL_RST 8'h00
`define BAUD_RST 8'h00
// Bus clock cycles per bit are (divisor + 1) times this
`define BIT_MULT 12'h010
`endif

// ===== core/serial_pkg.sv
// State types shared by the serial transmitter and receiver.
// Assumes the map header supplies all numbers.
package serial_pkg;
  typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} tx_state_e;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11
  } rx_state_e;
endpackage

// ===== core/serial_rx.sv
// Serial receiver: start detect, three-sample vote, 8 or 9 bit frames.
// Assumes rxd is already synchronised to clk and bit_cycles is at least 16.
`timescale 1ns/1ps
`include "serial_map.svh"
module serial_rx import serial_pkg::*; (
  input wire logic clk, // Bus clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic rxd, // Synchronised line level
  input wire logic enable, // Receiver on
  input wire logic nine, // 9-bit characters
  input wire logic par_en, // Parity check on
  input wire logic par_odd, // Odd parity
  input wire logic [11:0] bit_cycles, // Clocks per bit
  output logic done, // One-cycle pulse at stop bit
  output logic [8:0] data, // Received character
  output logic frame_err, // Stop bit was low
  output logic par_err, // Parity mismatch
  output logic noise, // Votes disagreed
  output logic brk, // All-zero frame
  output logic active // Reception in progress
);
  rx_state_e state_reg; // Receive sequencer
  logic [11:0] cnt_reg; // Cycle within bit
  logic [3:0] bitn_reg; // Data bits taken
  logic [8:0] shift_reg; // Incoming bits, LSB first
  logic s0_reg, s1_reg; // Early votes
  logic bit_reg; // Voted bit value
  logic noise_reg; // Noise seen in frame
  logic [11:0] half; // Mid-bit point
  logic vote; // Majority of three
  logic bit_end; // Last cycle of a bit
  logic [3:0] nbits; // Data bits per frame
  logic par_calc; // Xor of received bits

  assign half = {1'b0, bit_cycles[11:1]};
  assign vote = (s0_reg & s1_reg) | (s0_reg & rxd) | (s1_reg & rxd);
  assign bit_end = (cnt_reg == bit_cycles - 12'h001);
  assign nbits = nine ? 4'h9 : 4'h8; // [R10]
  assign par_calc = nine ? ^shift_reg : ^shift_reg[8:1];
  assign active = (state_reg != RX_IDLE);

  // Sampling around the bit centre; three votes reject single glitches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s0_reg <= 1'b0;
      s1_reg <= 1'b0;
      bit_reg <= 1'b1;
    end else begin
      if (cnt_reg == half - 12'h001) s0_reg <= rxd;
      if (cnt_reg == half) s1_reg <= rxd;
      if (cnt_reg == half + 12'h001) bit_reg <= vote;
    end
  end

  // Frame sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= RX_IDLE;
      cnt_reg <= 12'h000;
      bitn_reg <= 4'h0;
      shift_reg <= 9'h000;
      noise_reg <= 1'b0;
      done <= 1'b0;
      data <= 9'h000;
      frame_err <= 1'b0;
      par_err <= 1'b0;
      noise <= 1'b0;
      brk <= 1'b0;
    end else begin
      done <= 1'b0;
      cnt_reg <= (state_reg == RX_IDLE || bit_end) ? 12'h000 : cnt_reg + 12'h001;
      // Disagreeing votes mark the whole frame noisy
      if (state_reg != RX_IDLE && cnt_reg == half + 12'h001 &&
          !(s0_reg == s1_reg && s1_reg == rxd)) begin
        noise_reg <= 1'b1;
      end
      unique case (state_reg)
        RX_IDLE: begin
          noise_reg <= 1'b0;
          bitn_reg <= 4'h0;
          if (enable && !rxd) state_reg <= RX_START;
        end
        RX_START: begin
          // A start bit that votes high was a glitch
          if (bit_end) state_reg <= bit_reg ? RX_IDLE : RX_DATA;
        end
        RX_DATA: begin
          if (bit_end) begin
            shift_reg <= {bit_reg, shift_reg[8:1]};
            bitn_reg <= bitn_reg + 4'h1;
            if (bitn_reg == nbits - 4'h1) state_reg <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (bit_end) begin
            state_reg <= RX_IDLE;
            done <= 1'b1;
            data <= nine ? shift_reg : {1'b0, shift_reg[8:1]};
            frame_err <= !bit_reg;
            par_err <= par_en && (par_calc != par_odd);
            noise <= noise_reg;
            brk <= !bit_reg && ((nine ? shift_reg : {1'b0, shift_reg[8:1]}) == 9'h000);
          end
        end
      endcase
    end
  end
endmodule

// ===== dv/serial_node.sv
// Remote serial node: drives the receive line and catches frames from the transmit line.
// Assumes divisor 0, so every bit lasts 16 bus clocks.
`timescale 1ns/1ps
module serial_node (
  input wire logic clk, // Bus clock
  input wire logic txd, // Line from the block
  output logic rxd // Line into the block, pulled high
);
  localparam int BIT = 16; // Clocks per bit
  initial rxd = 1'b1; // Idle line rests high
  // One frame; stop level 0 with all-zero data makes a break, g adds a one-cycle spike mid data bit 0
  task automatic send(input logic [8:0] d, input int n, input logic stp, input logic g);
    logic b;
    for (int i = 0; i < n + 2; i++) begin
      b = (i == 0) ? 1'b0 : (i == n + 1) ? stp : d[i - 1];
      rxd <= b;
      repeat (BIT / 2) @(posedge clk);
      rxd <= (g && i == 1) ? ~b : b; // Spike lands on the vote window
      @(posedge clk);
      rxd <= b;
      repeat (BIT / 2 - 1) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge clk); // Gap lets the receiver post its flags
  endtask
  // Waits out the idle time, then samples each bit at its middle
  task automatic catch(input int n, input logic inv, output logic [8:0] d,
                       output logic stp, output int w);
    w = 0;
    d = 9'h000;
    while (txd === ~inv && w < 4000) begin
      @(posedge clk);
      w++;
    end
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (BIT) @(posedge clk);
      d[i] = txd ^ inv;
    end
    repeat (BIT) @(posedge clk);
    stp = txd ^ inv;
  endtask
endmodule

// ===== dv/serial_frame_ctrl_bench.sv
// Self-checking bench: register port, transmit frames, receive flags and requests.
// Assumes divisor 0 (16 clocks per bit) and the node model on both lines.
`timescale 1ns/1ps
`include "serial_map.svh"
module serial_frame_ctrl_bench;
  logic mclk = 1'b0; // Bus clock
  logic rstn = 1'b0; // Reset, active low
  logic [2:0] addr = 3'h0; // Register index
  logic [7:0] wdata = 8'h00; // Write data
  logic wr = 1'b0; // Write strobe
  logic rd = 1'b0; // Read strobe
  logic [7:0] rdata; // Read data
  logic rxd; // Node to block
  logic txd; // Block to node
  logic tx_irq; // Transmitter request
  logic err_irq; // Error request
  int fails = 0; // Mismatches
  int n_checks = 0; // Comparisons made
  int cyc = 0; // Cycles run
  serial_frame_ctrl DUT (.MCLK(mclk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .RXD(rxd), .TXD(txd), .TX_IRQ(tx_irq), .ERR_IRQ(err_irq));
  serial_node node (.clk(mclk), .txd(txd), .rxd(rxd));
  initial begin
    forever #10 mclk = ~mclk;
  end
  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe edge
  task automatic bus_rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk({1'b0, rdata & m}, {1'b0, e}, "register read");
  endtask
  // Requests are registered, so let them settle before looking
  task automatic irq_is(input logic [1:0] e);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk({7'h00, tx_irq, err_irq}, {7'h00, e}, "request lines");
  endtask
  // Preamble timing, character bits, completion and empty requests
  task automatic t_tx(input logic nine, input logic inv, input logic [8:0] d);
    logic [8:0] got;
    logic stp;
    int w;
    int b;
    b = nine ? 176 : 160;
    bus_wr(`ADDR_CTRL_ONE, {2'b00, inv, nine, 4'h0});
    bus_wr(`ADDR_CTRL_THREE, {1'b0, d[8], 6'h00});
    // Inverted run also enables the empty request while the buffer is loaded
    bus_wr(`ADDR_CTRL_TWO, {inv, 7'h48});
    bus_wr(`ADDR_DATA, d[7:0]);
    irq_is(2'b00);
    node.catch(nine ? 9 : 8, inv, got, stp, w);
    chk({8'h00, (w >= b - 10 && w <= b + 6)}, 9'h001, "idle length");
    chk(got, nine ? d : {1'b0, d[7:0]}, "sent character");
    chk({8'h00, stp}, 9'h001, "stop bit");
    repeat (40) @(posedge mclk);
    irq_is(2'b10);
    bus_wr(`ADDR_CTRL_TWO, 8'h80);
    irq_is(2'b10);
    chk({8'h00, txd}, {8'h00, ~inv}, "idle level");
    bus_wr(`ADDR_CTRL_TWO, 8'h00);
    irq_is(2'b00);
  endtask
  // One character in, then its data and received ninth bit
  task automatic t_rx(input logic nine, input logic [8:0] d, input logic r8);
    bus_wr(`ADDR_CTRL_ONE, {3'b000, nine, 4'h0});
    bus_wr(`ADDR_CTRL_TWO, 8'h04);
    node.send(d, nine ? 9 : 8, 1'b1, 1'b0);
    bus_rd(`ADDR_CTRL_THREE, 8'h80, {r8, 7'h00});
    bus_rd(`ADDR_DATA, 8'hFF, d[7:0]);
  endtask
  // Error source: gated request, flag held past the data read, then cleared
  task automatic t_err(input logic [7:0] c1, input logic [8:0] d, input int n,
                       input logic stp, input logic g, input logic [7:0] en,
                       input logic [7:0] m, input logic [7:0] e);
    bus_wr(`ADDR_CTRL_ONE, c1);
    bus_wr(`ADDR_CTRL_TWO, 8'h04);
    repeat (n) node.send(d, 8, stp, g);
    irq_is(2'b00);
    bus_wr(`ADDR_CTRL_THREE, en);
    irq_is(2'b01);
    bus_rd(`ADDR_STAT_ONE, m, e);
    bus_rd(`ADDR_DATA, 8'h7F, {1'b0, d[6:0]});
    bus_rd(`ADDR_STAT_ONE, m & 8'h0F, e & 8'h0F);
    irq_is(2'b01);
    bus_wr(`ADDR_STAT_ONE, 8'h0F);
    irq_is(2'b00);
    bus_wr(`ADDR_CTRL_THREE, 8'h00);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    bus_rd(`ADDR_STAT_ONE, 8'hFF, 8'hC0);
    bus_rd(`ADDR_CTRL_THREE, 8'h7F, 8'h00);
    bus_rd(3'h7, 8'hFF, 8'h00);
    t_tx(1'b0, 1'b0, 9'h0A5);
    t_tx(1'b1, 1'b0, 9'h13C);
    t_tx(1'b0, 1'b1, 9'h096);
    t_rx(1'b1, 9'h13C, 1'b1);
    t_rx(1'b0, 9'h001, 1'b0);
    t_rx(1'b0, 9'h0C1, 1'b1);
    t_err(8'h00, 9'h000, 1, 1'b0, 1'b0, 8'h02, 8'h22, 8'h22);
    bus_rd(`ADDR_STAT_TWO, 8'h02, 8'h02);
    bus_rd(`ADDR_CTRL_THREE, 8'h80, 8'h00);
    t_err(8'h00, 9'h055, 2, 1'b1, 1'b0, 8'h08, 8'h2F, 8'h28);
    t_err(8'h02, 9'h001, 1, 1'b1, 1'b0, 8'h01, 8'h2F, 8'h21);
    t_err(8'h00, 9'h000, 1, 1'b1, 1'b1, 8'h04, 8'h2F, 8'h24);
    give_verdict();
  end
endmodule
